// ===== design/adc_link_pkg.sv
// Shared constants for the converter serial link, both ends
// What this block does
// - Host drives all converters from one clock
// - Async sync release aligns within one clock
// - Slave mode allows several instructions per period
// - Master mode runs one instruction per period
// - Result update uses offset and gain registers
// - Result read in progress blocks the update
// - Host finishes 24 clocks before ready low; GUARD_CYC is declared but no logic uses it
// - Data pin driven only while transmitting
// - Chip select holds off or enables transfers
// - Master mode: chip select low reuses stored read instruction
// - Continuous read enabled after first select high
// - Data pin defaults input; high bit reads
// - All-zero instruction writes result, no action
// - Default result rate gives long period
// - Mode high makes device the clock master
// - Master serial clock is quarter rate
// - Unread result overwritten, ready raised on the same edge
// - Mode low: host supplies the serial clock
// - Host clock at most master clock over ten
// - Pin turns to output six to eight clocks in slave mode, five in master mode
// - Idle period still updates result
// - Sync resets modulator count, keeps conversion
// - Stalled transfer resets link after 4 periods
package adc_link_pkg;
  // ==========================================
  // Timing, sizes, instruction codes and reset values
  localparam int CLK_HZ = 100000000;
  localparam int RESULT_HZ = 326;
  localparam int PERIOD_CYC = CLK_HZ / RESULT_HZ;
  localparam int GUARD_CYC = 24;
  localparam int TURN_CYC = 7;
  localparam int EDGE_LAG_CYC = 3;
  localparam int STALL_PERIODS = 4;
  localparam int SLAVE_DIV = 10;
  localparam int MASTER_DIV = 4;
  localparam int READ_BITS = 32;
  localparam int INSTR_BITS = 8;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam logic [7:0] INSTR_READ_BIT = 8'h80;
  localparam logic [7:0] INSTR_RESET = 8'h00;
  localparam logic [31:0] OFFSET_RESET = 32'h00000000;
  localparam logic [31:0] GAIN_RESET = 32'h00000001;
endpackage : adc_link_pkg

// ===== design/adc_link_if.sv
// Interface joining the converter end and the controller end
interface adc_link_if;
  logic mode;
  logic sclk_dev;
  logic sclk_dev_oe;
  logic sclk_host;
  logic cs_n;
  logic result_ready_n;
  logic conversion_sync_n;
  logic sdio_dev;
  logic sdio_dev_oe;
  logic sdio_host;
  logic sdio_host_oe;
  logic serial_out_pin;
  modport dev (
    input mode, sclk_host, cs_n, conversion_sync_n, sdio_host,
    output sclk_dev, sclk_dev_oe, result_ready_n, sdio_dev, sdio_dev_oe,
    output serial_out_pin
  );
  modport host (
    output mode, sclk_host, cs_n, conversion_sync_n, sdio_host,
    output sdio_host_oe,
    input sclk_dev, sclk_dev_oe, result_ready_n, sdio_dev, sdio_dev_oe,
    input serial_out_pin
  );
endinterface : adc_link_if

// ===== design/result_fifo.sv
// Parameterised flip-flop FIFO for result words
module result_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : result_fifo

// ===== design/adc_dev_end.sv
// Converter end of the serial link
module adc_dev_end #(
  parameter int PERIOD_CYC = adc_link_pkg::PERIOD_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Link
  adc_link_if.dev link,
  // Result source and calibration
  input wire logic [31:0] raw_in,
  input wire logic [31:0] offset_in,
  input wire logic [31:0] gain_in,
  // Status
  output logic [23:0] mod_count_out,
  output logic [7:0] instr_out
);
  typedef enum {IDLE, INSTR, TURN, DATA, DONE} dev_state_t;
  dev_state_t state;
  logic [1:0] mode_s, cs_s, sync_s, sck_s, sdi_s;
  logic mode, cs_n, sync_n, sck;
  logic sck_prev;
  logic sck_rise, sck_fall;
  logic [31:0] period_cnt;
  logic [31:0] stall_cnt;
  logic [31:0] result_output_reg;
  logic [31:0] offset_cal_reg;
  logic [31:0] gain_cal_reg;
  logic [31:0] shreg;
  logic [7:0] instr;
  logic [5:0] bits;
  logic [3:0] turn_cnt;
  logic [1:0] div_cnt;
  logic mclk_sck;
  logic ready_n;
  logic cont_enabled;
  logic cs_seen_high;
  logic done_this_period;
  logic update_now;
  logic update_d;
  logic reading;
  // ==========================================
  // Input synchronisers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_s <= '0;
      cs_s <= 2'h3;
      sync_s <= 2'h3;
      sck_s <= '0;
      sdi_s <= '0;
    end else begin
      mode_s <= {mode_s[0], link.mode};
      cs_s <= {cs_s[0], link.cs_n};
      sync_s <= {sync_s[0], link.conversion_sync_n};
      sck_s <= {sck_s[0], link.sclk_host};
      sdi_s <= {sdi_s[0], link.sdio_host};
    end
  end
  assign mode = mode_s[1];
  assign cs_n = cs_s[1];
  assign sync_n = sync_s[1];
  assign sck = mode ? mclk_sck : sck_s[1];
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) sck_prev <= 1'b0;
    else sck_prev <= sck;
  end
  assign sck_rise = sck && !sck_prev;
  assign sck_fall = !sck && sck_prev;
  // ==========================================
  // Master serial clock divider
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt <= '0;
      mclk_sck <= 1'b0;
    end else if (mode && (state == INSTR || state == DATA)) begin
      div_cnt <= div_cnt + 2'h1;
      if (div_cnt == 2'h1) mclk_sck <= 1'b1;
      if (div_cnt == 2'h3) mclk_sck <= 1'b0;
    end else begin
      div_cnt <= '0;
      mclk_sck <= 1'b0;
    end
  end
  // ==========================================
  // Conversion period and modulator count
  assign update_now = (period_cnt == 32'(PERIOD_CYC - 1));
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      period_cnt <= '0;
      update_d <= 1'b0;
      mod_count_out <= '0;
    end else begin
      period_cnt <= update_now ? '0 : period_cnt + 32'h1;
      update_d <= update_now;
      if (!sync_n) mod_count_out <= '0;
      else mod_count_out <= mod_count_out + 24'h1;
    end
  end
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      offset_cal_reg <= adc_link_pkg::OFFSET_RESET;
      gain_cal_reg <= adc_link_pkg::GAIN_RESET;
    end else begin
      offset_cal_reg <= offset_in;
      gain_cal_reg <= gain_in;
    end
  end
  assign reading = (state == DATA) && instr[7];
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) result_output_reg <= '0;
    else if (update_now && !reading)
      result_output_reg <=
          32'((raw_in - offset_cal_reg) * gain_cal_reg);
    else if (state == DONE && !instr[7] && instr == adc_link_pkg::INSTR_RESET)
      result_output_reg <= result_output_reg;
  end
  // ==========================================
  // Continuous read tracking
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cont_enabled <= 1'b0;
      cs_seen_high <= 1'b0;
    end else begin
      if (cs_n) cont_enabled <= 1'b1;
      if (cs_n) cs_seen_high <= 1'b1;
      else if (state == DONE) cs_seen_high <= 1'b0;
    end
  end
  // ==========================================
  // Transfer sequencer
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= IDLE;
      ready_n <= 1'b1;
      instr <= adc_link_pkg::INSTR_RESET;
      shreg <= '0;
      bits <= '0;
      turn_cnt <= '0;
      done_this_period <= 1'b0;
      stall_cnt <= '0;
    end else begin
      if (update_now) begin
        ready_n <= 1'b1;
        done_this_period <= 1'b0;
      end else if (update_d) begin
        ready_n <= 1'b0;
      end
      if (state != IDLE && !sck_rise && !sck_fall) begin
        stall_cnt <= stall_cnt + 32'h1;
      end else begin
        stall_cnt <= '0;
      end
      case (state)
        IDLE: begin
          if (mode && !ready_n && !cs_n && !done_this_period) begin
            if (cont_enabled && !cs_seen_high && instr[7]) begin
              shreg <= result_output_reg;
              bits <= '0;
              state <= TURN;
            end else begin
              bits <= '0;
              state <= INSTR;
            end
          end else if (!mode && !cs_n && sck_rise) begin
            shreg <= {31'h0, sdi_s[1]};
            bits <= 6'h1;
            state <= INSTR;
          end
        end
        INSTR: begin
          if (sck_rise) begin
            shreg <= {shreg[30:0], sdi_s[1]};
            bits <= bits + 6'h1;
          end
          if (sck_fall && bits == 6'(adc_link_pkg::INSTR_BITS)) begin
            instr <= shreg[7:0];
            shreg <= result_output_reg;
            bits <= '0;
            turn_cnt <= '0;
            state <= TURN;
          end
        end
        TURN: begin
          turn_cnt <= turn_cnt + 4'h1;
          if (turn_cnt == 4'(adc_link_pkg::TURN_CYC
              - adc_link_pkg::EDGE_LAG_CYC - 1)) begin
            state <= DATA;
          end
        end
        DATA: begin
          if (sck_fall) begin
            shreg <= {shreg[30:0], 1'b0};
            bits <= bits + 6'h1;
            if (bits == 6'(adc_link_pkg::READ_BITS - 1)) state <= DONE;
          end
        end
        DONE: begin
          done_this_period <= 1'b1;
          if (!mode) ready_n <= 1'b1;
          state <= IDLE;
        end
        default: state <= IDLE;
      endcase
      if (stall_cnt >= 32'(adc_link_pkg::STALL_PERIODS
          * PERIOD_CYC)) begin
        state <= IDLE;
      end
    end
  end
  // ==========================================
  // Pin drive
  assign link.result_ready_n = ready_n;
  assign link.sclk_dev = mclk_sck;
  assign link.sclk_dev_oe = mode;
  assign link.sdio_dev = shreg[31];
  assign link.sdio_dev_oe = (state == DATA) && instr[7];
  assign link.serial_out_pin = shreg[31];
  assign instr_out = instr;
endmodule : adc_dev_end

// ===== design/adc_host_end.sv
// Controller end of the serial link
module adc_host_end (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // User side
  input wire logic mode_in,
  input wire logic sync_req_in,
  input wire logic out_ready_in,
  output logic out_valid_out,
  output logic [31:0] out_data_out,
  // Link
  adc_link_if.host link
);
  typedef enum {H_IDLE, H_INSTR, H_WAIT, H_DATA} host_state_t;
  host_state_t state;
  logic [1:0] rdy_s, sdo_s, oe_s;
  logic got_word;
  logic [3:0] div;
  logic tick;
  logic sck;
  logic [7:0] ishift;
  logic [31:0] dshift;
  logic [5:0] bits;
  logic push;
  logic fifo_ready;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_s <= 2'h3;
      sdo_s <= '0;
      oe_s <= '0;
    end else begin
      rdy_s <= {rdy_s[0], link.result_ready_n};
      sdo_s <= {sdo_s[0], link.sdio_dev};
      oe_s <= {oe_s[0], link.sdio_dev_oe};
    end
  end
  // ==========================================
  // Slow serial clock enable
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) div <= '0;
    else if (div == 4'(adc_link_pkg::SLAVE_DIV - 1)) div <= '0;
    else div <= div + 4'h1;
  end
  assign tick = (div == 4'h0) || (div == 4'(adc_link_pkg::SLAVE_DIV / 2));
  // ==========================================
  // Slave-mode read sequencer
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= H_IDLE;
      sck <= 1'b0;
      ishift <= '0;
      dshift <= '0;
      bits <= '0;
      push <= 1'b0;
      got_word <= 1'b0;
    end else begin
      push <= 1'b0;
      if (rdy_s[1]) got_word <= 1'b0;
      case (state)
        H_IDLE: begin
          if (!mode_in && !rdy_s[1] && fifo_ready && !got_word) begin
            ishift <= adc_link_pkg::INSTR_READ_BIT;
            bits <= '0;
            state <= H_INSTR;
          end
        end
        H_INSTR: if (tick) begin
          sck <= !sck;
          if (sck) begin
            ishift <= {ishift[6:0], 1'b0};
            bits <= bits + 6'h1;
            if (bits == 6'(adc_link_pkg::INSTR_BITS - 1)) begin
              bits <= '0;
              state <= H_WAIT;
            end
          end
        end
        H_WAIT: if (tick && oe_s[1]) state <= H_DATA;
        H_DATA: if (tick) begin
          sck <= !sck;
          if (sck) begin
            dshift <= {dshift[30:0], sdo_s[1]};
            bits <= bits + 6'h1;
            if (bits == 6'(adc_link_pkg::READ_BITS - 1)) begin
              push <= 1'b1;
              got_word <= 1'b1;
              state <= H_IDLE;
            end
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
  result_fifo #(.WIDTH(adc_link_pkg::DATA_W),
    .DEPTH(adc_link_pkg::FIFO_DEPTH)) u_fifo (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_data_in(dshift),
    .in_ready_out(fifo_ready),
    .out_valid_out(out_valid_out),
    .out_data_out(out_data_out),
    .out_ready_in(out_ready_in)
  );
  assign link.mode = mode_in;
  assign link.sclk_host = sck;
  assign link.cs_n = (state == H_IDLE);
  assign link.conversion_sync_n = !sync_req_in;
  assign link.sdio_host = ishift[7];
  assign link.sdio_host_oe = (state == H_INSTR);
endmodule : adc_host_end

// ===== verif/adc_serial_port_control_monitor.sv
// Checker of the converter serial link signals
module adc_serial_port_control_monitor (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Link signals
  input wire logic mode,
  input wire logic sclk_dev,
  input wire logic sclk_dev_oe,
  input wire logic sclk_host,
  input wire logic cs_n,
  input wire logic result_ready_n,
  input wire logic sdio_dev_oe,
  input wire logic sdio_host_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] oe_cnt;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // Data enable length
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      oe_cnt <= 10'h000;
    end else if (sdio_dev_oe) begin
      oe_cnt <= oe_cnt + 10'h001;
    end else begin
      oe_cnt <= 10'h000;
    end
  end
  // ==========================================
  // Properties
  property p_oe_excl;
    !(sdio_dev_oe && sdio_host_oe);
  endproperty
  a_oe_excl: assert property (p_oe_excl)
    else $error("both ends drive the data line");
  property p_turn;
    $rose(sdio_dev_oe) && !mode |->
      $past(sclk_host, 9) && !$past(sclk_host, 6) && !sclk_host;
  endproperty
  a_turn: assert property (p_turn)
    else $error("data line turned outside six to eight cycles");
  property p_oe_len;
    oe_cnt <= 10'h190;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("device drives data line too long");
  property p_cs_gate;
    $rose(sdio_dev_oe) && !mode |-> !cs_n && !$past(cs_n, 8);
  endproperty
  a_cs_gate: assert property (p_cs_gate)
    else $error("slave transmit without chip select");
  property p_ready_after;
    $fell(sdio_dev_oe) && !mode |-> ##[0:10] result_ready_n;
  endproperty
  a_ready_after: assert property (p_ready_after)
    else $error("ready not high after slave read");
  property p_sclk_dir;
    (!mode) [*4] |-> !sclk_dev_oe;
  endproperty
  a_sclk_dir: assert property (p_sclk_dir)
    else $error("device drives clock in slave mode");
  property p_master_rate;
    sclk_dev_oe && $rose(sclk_dev) |-> ##2 $fell(sclk_dev);
  endproperty
  a_master_rate: assert property (p_master_rate)
    else $error("master clock not quarter rate");
  property p_cs_hold;
    sdio_dev_oe && $rose(cs_n) && oe_cnt < 10'h190 |=> sdio_dev_oe;
  endproperty
  a_cs_hold: assert property (p_cs_hold)
    else $error("chip select released the data driver");
endmodule : adc_serial_port_control_monitor

// ===== verif/adc_serial_port_control_test.sv
// Self-checking bench joining both ends of the converter link
module adc_serial_port_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mode_in = 1'b0;
  logic sync_req_in = 1'b0;
  logic out_ready_in = 1'b0;
  logic [31:0] raw_in = 32'h00001234;
  logic [31:0] offset_in = 32'h00000034;
  logic [31:0] gain_in = 32'h00000003;
  logic out_valid_out;
  logic [31:0] out_data_out;
  logic [23:0] mod_count_out;
  logic [7:0] instr_out;
  int n_fail = 0;
  int tests_run = 0;
  localparam int SHORT_PERIOD = 3000;
  // ==========================================
  // Design and checker
  always #5 mclk_in = ~mclk_in;
  adc_link_if link ();
  adc_dev_end #(.PERIOD_CYC(SHORT_PERIOD)) adc_dev_end_i (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .link(link), .raw_in(raw_in), .offset_in(offset_in),
    .gain_in(gain_in), .mod_count_out(mod_count_out),
    .instr_out(instr_out));
  adc_host_end adc_host_end_i (.mclk_in(mclk_in), .rst_in(rst_in),
    .mode_in(mode_in), .sync_req_in(sync_req_in),
    .out_ready_in(out_ready_in), .out_valid_out(out_valid_out),
    .out_data_out(out_data_out), .link(link));
  adc_serial_port_control_monitor adc_serial_port_control_monitor_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .mode(link.mode),
    .sclk_dev(link.sclk_dev), .sclk_dev_oe(link.sclk_dev_oe),
    .sclk_host(link.sclk_host), .cs_n(link.cs_n),
    .result_ready_n(link.result_ready_n),
    .sdio_dev_oe(link.sdio_dev_oe), .sdio_host_oe(link.sdio_host_oe));
  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic read_word(input logic [31:0] exp);
    int i;
    for (i = 0; i < 20000 && out_valid_out !== 1'b1; i++) begin
      @(negedge mclk_in);
    end
    if (i == 20000) begin
      n_fail++;
      $display("BAD result wait expected %h seen %h", 1'b1, 1'b0);
      summarize();
    end
    repeat (20) @(negedge mclk_in);
    check("result word", out_data_out, exp);
    out_ready_in = 1'b1;
    @(negedge mclk_in);
    out_ready_in = 1'b0;
  endtask : read_word
  // ==========================================
  // Sequence
  initial begin
    repeat (12) @(negedge mclk_in);
    check("ready idle", {31'h0, link.result_ready_n}, 32'h1);
    check("data enable idle", {31'h0, link.sdio_dev_oe}, 32'h0);
    check("clock enable idle", {31'h0, link.sclk_dev_oe}, 32'h0);
    rst_in = 1'b0;
    $display("Test reset levels done");
    repeat (50) @(negedge mclk_in);
    sync_req_in = 1'b1;
    repeat (30) @(negedge mclk_in);
    check("count cleared", {31'h0, mod_count_out < 24'h000010}, 32'h1);
    sync_req_in = 1'b0;
    $display("Test sync done");
    read_word((raw_in - offset_in) * gain_in);
    check("ready after read", {31'h0, link.result_ready_n}, 32'h1);
    check("read bit", {24'h0, instr_out & adc_link_pkg::INSTR_READ_BIT},
      {24'h0, adc_link_pkg::INSTR_READ_BIT});
    $display("Test first result done");
    raw_in = 32'h00100000;
    offset_in = 32'h00000010;
    gain_in = 32'h00000002;
    repeat (2000) @(negedge mclk_in);
    read_word((raw_in - offset_in) * gain_in);
    check("enable released", {31'h0, link.sdio_dev_oe}, 32'h0);
    $display("Test second result done");
    mode_in = 1'b1;
    for (int k = 0; k < 4000 && link.result_ready_n !== 1'b0; k++) begin
      @(negedge mclk_in);
    end
    repeat (40) @(negedge mclk_in);
    check("clock enable master", {31'h0, link.sclk_dev_oe}, 32'h1);
    check("master ready held", {31'h0, link.result_ready_n}, 32'h0);
    check("master clock held", {31'h0, link.sclk_dev}, 32'h0);
    check("master data held", {31'h0, link.sdio_dev_oe}, 32'h0);
    $display("Test master hold-off done");
    summarize();
  end
endmodule : adc_serial_port_control_test
